/* common/estop_pkg.sv */
package estop_pkg;

  // ****************************************************************
  // clock and millisecond tick
  // ****************************************************************
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

  // ****************************************************************
  // delays in ms
  // ****************************************************************
  localparam int DELAY_W = 14;
  localparam logic [13:0] DELAY_MAX_MS = 14'h2710;    // 10000 ms
  localparam logic [13:0] DELAY_RESET = 14'h0000;     // 0 ms after reset
  localparam logic [13:0] ELAPSED_SAT = 14'h3fff;     // elapsed counter stops here
  localparam int STOP_FAIL_S = 10;
  localparam logic [13:0] STOP_FAIL_MS = 14'(STOP_FAIL_S * 1000);

  // ****************************************************************
  // torque in percent
  // ****************************************************************
  localparam int TORQUE_W = 10;
  localparam logic [9:0] TORQUE_MAX_PCT = 10'h320;    // 800 %
  localparam logic [9:0] TORQUE_RESET = 10'h320;      // 800 % after reset

  // ****************************************************************
  // configuration digits and status mapping
  // ****************************************************************
  localparam logic ESTOP_EN_RESET = 1'b0;
  localparam logic CONTACTOR_EN_RESET = 1'b0;
  localparam int MAP_W = 3;
  localparam logic [2:0] MAP_RESET = 3'h0;            // unmapped
  localparam int MAP_BITS = 7;                        // status bits 24 to 30
  localparam int MAP_FIRST_BIT = 24;

  // ****************************************************************
  // per-axis stop sequence
  // ****************************************************************
  typedef enum logic [1:0] {
    AXIS_RUN,
    AXIS_WAIT,
    AXIS_DECEL,
    AXIS_BLOCKED
  } axis_state_e;

endpackage : estop_pkg

/* hw/emergency_stop_sequencer.sv */
module emergency_stop_sequencer
  import estop_pkg::*;
#(
  parameter int NUM_AXES = 2,
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic restartReq,
  // stop input and motion feedback
  input wire logic stopInputPos,
  input wire logic [NUM_AXES-1:0] motorStopped,
  input wire logic [NUM_AXES-1:0] overtravel,
  input wire logic [NUM_AXES-1:0] axisIsSpindle,
  // configuration per axis; cfgContactorEnable is taken from axis 0 alone
  input wire logic [NUM_AXES-1:0] cfgStopEnable,
  input wire logic [NUM_AXES-1:0] cfgContactorEnable,
  input wire logic [NUM_AXES-1:0][TORQUE_W-1:0] stopTorqueLimit,
  input wire logic [NUM_AXES-1:0][TORQUE_W-1:0] spindlePoweringTorque,
  input wire logic [NUM_AXES-1:0][TORQUE_W-1:0] spindleRegenTorque,
  input wire logic [NUM_AXES-1:0][DELAY_W-1:0] stopStartDelay,
  input wire logic [NUM_AXES-1:0][DELAY_W-1:0] contactorOffDelay,
  input wire logic [NUM_AXES-1:0][MAP_W-1:0] stopStateBitMap,
  // host requests
  input wire logic [NUM_AXES-1:0] contactorOnRequest,
  input wire logic alarmClear,
  // axis drive outputs
  output logic [NUM_AXES-1:0] decelActive,
  output logic [NUM_AXES-1:0] baseBlock,
  output logic [NUM_AXES-1:0][TORQUE_W-1:0] decelTorquePower,
  output logic [NUM_AXES-1:0][TORQUE_W-1:0] decelTorqueRegen,
  // status and alarms
  output logic [NUM_AXES-1:0] stopStateFlag,
  output logic [NUM_AXES-1:0][MAP_BITS-1:0] monitorBits,
  output logic [NUM_AXES-1:0] undervoltageAlarm,
  output logic [NUM_AXES-1:0] stopFailAlarm,
  output logic [NUM_AXES-1:0] mainReadyStatus,
  // contactor drive
  output logic mainContactor
);

  localparam int TICK_W = (TICK_COUNT > 1) ? $clog2(TICK_COUNT) : 1;

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // limit a torque setting to the top of its range
  function automatic logic [TORQUE_W-1:0] clampTorque(input logic [TORQUE_W-1:0] value);
    clampTorque = (value > TORQUE_MAX_PCT) ? TORQUE_MAX_PCT : value;
  endfunction : clampTorque

  // limit a delay setting to the top of its range
  function automatic logic [DELAY_W-1:0] clampDelay(input logic [DELAY_W-1:0] value);
    clampDelay = (value > DELAY_MAX_MS) ? DELAY_MAX_MS : value;
  endfunction : clampDelay

  // one-hot status position for a map digit, zero when unmapped
  function automatic logic [MAP_BITS-1:0] mapBit(input logic [MAP_W-1:0] sel, input logic flag);
    logic [MAP_BITS-1:0] result;
    result = '0;
    if (sel != MAP_RESET && flag) begin
      result = MAP_BITS'(1) << (sel - 3'h1);
    end
    mapBit = result;
  endfunction : mapBit

  // ****************************************************************
  // restart capture of after-restart settings
  // ****************************************************************
  logic configLoaded;
  logic [NUM_AXES-1:0] stopEnable;
  logic contactorEnable;
  logic [NUM_AXES-1:0][DELAY_W-1:0] offDelay;
  logic [NUM_AXES-1:0][MAP_W-1:0] bitMap;
  logic [DELAY_W-1:0] effOffDelay;

  // settings are taken on the first edge after reset release or on restart
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      configLoaded <= 1'b0;
      stopEnable <= {NUM_AXES{ESTOP_EN_RESET}};
      contactorEnable <= CONTACTOR_EN_RESET;
      offDelay <= {NUM_AXES{DELAY_RESET}};
      bitMap <= {NUM_AXES{MAP_RESET}};
    end else begin
      configLoaded <= 1'b1;
      if (!configLoaded || restartReq) begin
        stopEnable <= cfgStopEnable;
        contactorEnable <= cfgContactorEnable[0];
        for (int i = 0; i < NUM_AXES; i++) begin
          offDelay[i] <= clampDelay(contactorOffDelay[i]);
          bitMap[i] <= stopStateBitMap[i];
        end
      end
    end
  end

  // largest contactor delay among the axes on the converter
  always_comb begin
    effOffDelay = '0;
    for (int i = 0; i < NUM_AXES; i++) begin
      if (offDelay[i] > effOffDelay) begin
        effOffDelay = offDelay[i];
      end
    end
  end

  // ****************************************************************
  // stop input and millisecond timebase
  // ****************************************************************
  logic inStop;
  logic prevStop;
  logic stopEdge;
  logic [TICK_W-1:0] tickCount;
  logic tick;
  logic [DELAY_W-1:0] elapsedMs;

  assign inStop = !stopInputPos;
  assign stopEdge = inStop && !prevStop;
  assign tick = (tickCount == TICK_W'(TICK_COUNT - 1));

  // previous stop level for edge detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prevStop <= 1'b0;
    end else begin
      prevStop <= inStop;
    end
  end

  // prescaler restarts on the stop edge so the first ms is whole
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tickCount <= '0;
    end else if (stopEdge || !inStop || tick) begin
      tickCount <= '0;
    end else begin
      tickCount <= tickCount + TICK_W'(1);
    end
  end

  // ms since the stop began, zero while released
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      elapsedMs <= '0;
    end else if (!inStop || stopEdge) begin
      elapsedMs <= '0;
    end else if (tick && elapsedMs != ELAPSED_SAT) begin
      elapsedMs <= elapsedMs + DELAY_W'(1);
    end
  end

  // ****************************************************************
  // per-axis stop sequence
  // ****************************************************************
  axis_state_e axisState [NUM_AXES];

  // run, wait for start delay, decelerate, base block
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_AXES; i++) begin
        axisState[i] <= AXIS_RUN;
      end
    end else begin
      for (int i = 0; i < NUM_AXES; i++) begin
        case (axisState[i])
          AXIS_RUN: begin
            if (stopEnable[i] && inStop) begin
              axisState[i] <= AXIS_WAIT;
            end
          end
          AXIS_WAIT: begin
            if (!inStop) begin
              axisState[i] <= AXIS_RUN;
            end else if (elapsedMs >= clampDelay(stopStartDelay[i])) begin
              axisState[i] <= AXIS_DECEL;
            end
          end
          AXIS_DECEL: begin
            if (motorStopped[i]) begin
              axisState[i] <= AXIS_BLOCKED;
            end
          end
          AXIS_BLOCKED: begin
            if (!inStop) begin
              axisState[i] <= AXIS_RUN;
            end
          end
          default: begin
            axisState[i] <= AXIS_RUN;
          end
        endcase
      end
    end
  end

  // drive state and deceleration torque selection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      decelActive <= '0;
      baseBlock <= '0;
      decelTorquePower <= {NUM_AXES{TORQUE_RESET}};
      decelTorqueRegen <= {NUM_AXES{TORQUE_RESET}};
    end else begin
      for (int i = 0; i < NUM_AXES; i++) begin
        decelActive[i] <= (axisState[i] == AXIS_DECEL) || overtravel[i];
        baseBlock[i] <= (axisState[i] == AXIS_BLOCKED);
        if (overtravel[i] && axisIsSpindle[i] && axisState[i] != AXIS_DECEL) begin
          decelTorquePower[i] <= clampTorque(spindlePoweringTorque[i]);
          decelTorqueRegen[i] <= clampTorque(spindleRegenTorque[i]);
        end else begin
          decelTorquePower[i] <= clampTorque(stopTorqueLimit[i]);
          decelTorqueRegen[i] <= clampTorque(stopTorqueLimit[i]);
        end
      end
    end
  end

  // ****************************************************************
  // main contactor
  // ****************************************************************
  logic next_mainContactor;

  // any request closes it; converter control opens it after the delay
  always_comb begin
    next_mainContactor = |contactorOnRequest;
    if (contactorEnable && inStop && elapsedMs >= effOffDelay) begin
      next_mainContactor = 1'b0;
    end
  end

  // registered contactor drive and main ready
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mainContactor <= 1'b0;
      mainReadyStatus <= '0;
    end else begin
      mainContactor <= next_mainContactor;
      mainReadyStatus <= {NUM_AXES{mainContactor}};
    end
  end

  // ****************************************************************
  // status mapping
  // ****************************************************************

  // stop state flag follows the input, mapped into one status bit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stopStateFlag <= '0;
      monitorBits <= '0;
    end else begin
      for (int i = 0; i < NUM_AXES; i++) begin
        stopStateFlag[i] <= inStop;
        monitorBits[i] <= mapBit(bitMap[i], inStop);
      end
    end
  end

  // ****************************************************************
  // alarms
  // ****************************************************************

  // sticky alarms; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      undervoltageAlarm <= '0;
      stopFailAlarm <= '0;
    end else begin
      for (int i = 0; i < NUM_AXES; i++) begin
        if (axisState[i] == AXIS_DECEL && !mainContactor) begin
          undervoltageAlarm[i] <= 1'b1;
        end else if (alarmClear) begin
          undervoltageAlarm[i] <= 1'b0;
        end
        if (stopEnable[i] && inStop && elapsedMs >= STOP_FAIL_MS && !motorStopped[i]
            && axisState[i] != AXIS_BLOCKED) begin
          stopFailAlarm[i] <= 1'b1;
        end else if (alarmClear) begin
          stopFailAlarm[i] <= 1'b0;
        end
      end
    end
  end

endmodule : emergency_stop_sequencer

/* dv/estop_checker.sv */
module estop_checker
  import estop_pkg::*;
#(
  parameter int NUM_AXES = 2,
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // watched inputs
  input wire logic stopInputPos,
  input wire logic [NUM_AXES-1:0] motorStopped,
  input wire logic [NUM_AXES-1:0] overtravel,
  input wire logic [NUM_AXES-1:0] axisIsSpindle,
  input wire logic [NUM_AXES-1:0][TORQUE_W-1:0] stopTorqueLimit,
  input wire logic [NUM_AXES-1:0] contactorOnRequest,
  // watched outputs
  input wire logic [NUM_AXES-1:0] baseBlock,
  input wire logic [NUM_AXES-1:0][TORQUE_W-1:0] decelTorquePower,
  input wire logic [NUM_AXES-1:0] stopStateFlag,
  input wire logic [NUM_AXES-1:0][MAP_BITS-1:0] monitorBits,
  input wire logic [NUM_AXES-1:0] undervoltageAlarm,
  input wire logic [NUM_AXES-1:0] stopFailAlarm,
  input wire logic mainContactor
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic [31:0] stopCycles;
  // cycles spent with the stop input low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stopCycles <= 32'h0;
    end else begin
      stopCycles <= stopInputPos ? 32'h0 : stopCycles + 32'h1;
    end
  end
  // ****
  // properties
  // ****
  a_flag_follows_input: assert property (
    ##1 stopStateFlag == {NUM_AXES{!$past(stopInputPos)}})
    else $error("stop flag does not follow input");
  a_map_one_hot: assert property (
    monitorBits[0] != 7'h00 |-> stopStateFlag[0] && $onehot(monitorBits[0]))
    else $error("monitor bits not one-hot stop flag");
  a_contactor_closes: assert property (
    stopInputPos && $past(stopInputPos) && (|contactorOnRequest) |=> mainContactor)
    else $error("contactor open despite request");
  a_contactor_opens: assert property (
    !(|contactorOnRequest) |=> !mainContactor)
    else $error("contactor closed without request");
  a_stop_torque_used: assert property (
    !(overtravel[0] && axisIsSpindle[0]) |=> decelTorquePower[0] == $past(stopTorqueLimit[0]))
    else $error("wrong deceleration torque");
  a_block_on_standstill: assert property (
    $rose(baseBlock[0]) |-> $past(motorStopped[0]))
    else $error("base block before standstill");
  a_fail_after_ten_s: assert property (
    $rose(stopFailAlarm[0]) |-> stopCycles >= 32'(10000 * TICK_COUNT))
    else $error("stop failure alarm too early");
  a_uv_cause: assert property (
    $rose(undervoltageAlarm[0]) |-> !$past(mainContactor))
    else $error("undervoltage alarm with contactor closed");
endmodule : estop_checker

bind emergency_stop_sequencer estop_checker #(.NUM_AXES(NUM_AXES), .TICK_COUNT(TICK_COUNT)) chk_u (
  .clock, .nrst, .stopInputPos, .motorStopped, .overtravel, .axisIsSpindle, .stopTorqueLimit,
  .contactorOnRequest, .baseBlock, .decelTorquePower, .stopStateFlag, .monitorBits,
  .undervoltageAlarm, .stopFailAlarm, .mainContactor);

/* dv/motor_model.sv */
module motor_model #(
  parameter int DECEL_CYCLES = 6
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // drive side and test controls
  input wire logic [1:0] decelActive,
  input wire logic [1:0] spin,
  input wire logic stall,
  // feedback
  output logic [1:0] motorStopped
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][3:0] speed;
  // speed drops one step per cycle of braking, a stalled motor never stops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      speed <= 8'h00;
    end else begin
      for (int a = 0; a < 2; a++) begin
        if (spin[a]) begin
          speed[a] <= 4'(DECEL_CYCLES);
        end else if (decelActive[a] && !stall && speed[a] != 4'h0) begin
          speed[a] <= speed[a] - 4'h1;
        end
      end
    end
  end
  // standstill flag
  assign motorStopped = {speed[1] == 4'h0, speed[0] == 4'h0};
endmodule : motor_model

/* dv/tb.sv */
module tb
  import estop_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, nrst, restartReq, stopInputPos, alarmClear, stall, mainContactor;
  logic [1:0] overtravel, axisIsSpindle, cfgStopEnable, cfgContactorEnable, contactorOnRequest, spin;
  logic [1:0] motorStopped, decelActive, baseBlock, stopStateFlag, undervoltageAlarm, stopFailAlarm;
  logic [1:0] mainReadyStatus, hostDecel;
  logic [1:0][9:0] stopTorqueLimit, spindlePoweringTorque, spindleRegenTorque, decelTorquePower;
  logic [1:0][9:0] decelTorqueRegen;
  logic [1:0][13:0] stopStartDelay, contactorOffDelay;
  logic [1:0][2:0] stopStateBitMap;
  logic [1:0][6:0] monitorBits;
  int fails = 0;
  int checks = 0;
  // design with a 4-cycle millisecond
  emergency_stop_sequencer #(.NUM_AXES(2), .TICK_COUNT(4)) dut_u (
    .clock, .nrst, .restartReq, .stopInputPos, .motorStopped, .overtravel, .axisIsSpindle,
    .cfgStopEnable, .cfgContactorEnable, .stopTorqueLimit, .spindlePoweringTorque, .spindleRegenTorque,
    .stopStartDelay, .contactorOffDelay, .stopStateBitMap, .contactorOnRequest, .alarmClear,
    .decelActive, .baseBlock, .decelTorquePower, .decelTorqueRegen, .stopStateFlag, .monitorBits,
    .undervoltageAlarm, .stopFailAlarm, .mainReadyStatus, .mainContactor);
  // motors brake on the design's command or on the host's own stop moves
  motor_model mot_u (.clock, .nrst, .decelActive(decelActive | hostDecel), .spin, .stall, .motorStopped);
  // ****
  // helpers
  // ****
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic restart();
    restartReq = 1'b1;
    cyc(1);
    restartReq = 1'b0;
  endtask : restart
  task automatic go_stop();
    spin = 2'h3;
    cyc(1);
    spin = 2'h0;
    stopInputPos = 1'b0;
  endtask : go_stop
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // watchdog
  initial begin
    repeat (50000) @(posedge clock);
    fails++;
    final_report();
  end
  // ****
  // tests
  // ****
  initial begin
    {nrst, restartReq, alarmClear, stall, overtravel, cfgStopEnable, cfgContactorEnable} = 10'h0;
    {contactorOnRequest, spin, stopStartDelay, contactorOffDelay, stopStateBitMap} = 66'h0;
    hostDecel = 2'h0;
    stopInputPos = 1'b1;
    axisIsSpindle = 2'h2;
    stopTorqueLimit = {2{10'h320}};
    spindlePoweringTorque = {10'h78, 10'h0};
    spindleRegenTorque = {10'h64, 10'h0};
    cyc(3);
    nrst = 1'b1;
    cyc(2);
    check("torque", decelTorquePower, {2{10'h320}});
    for (int r = 0; r < 4; r++) begin
      contactorOnRequest = 2'(r);
      cyc(1);
      check("contactor", mainContactor, r != 0);
    end
    cyc(1);
    check("ready", mainReadyStatus, 2'h3);
    $display("test contactor done");
    cfgStopEnable = 2'h3;
    go_stop();
    cyc(4);
    check("decel", decelActive, 2'h0);
    check("flag", stopStateFlag, 2'h3);
    check("map", monitorBits, 14'h0);
    check("contactor", mainContactor, 1'b1);
    hostDecel = 2'h3;
    cyc(8);
    check("stopped", motorStopped, 2'h3);
    contactorOnRequest = 2'h0;
    cyc(2);
    check("contactor", mainContactor, 1'b0);
    check("ready", mainReadyStatus, 2'h0);
    stopInputPos = 1'b1;
    hostDecel = 2'h0;
    contactorOnRequest = 2'h3;
    cyc(2);
    check("flag", stopStateFlag, 2'h0);
    check("ready", mainReadyStatus, 2'h3);
    $display("test defaults done");
    cfgContactorEnable = 2'h1;
    stopStartDelay = {14'h2, 14'h0};
    contactorOffDelay = {14'h3, 14'h1};
    stopStateBitMap = {3'h7, 3'h1};
    restart();
    go_stop();
    cyc(2);
    check("decel", decelActive, 2'h0);
    cyc(1);
    check("decel", decelActive, 2'h1);
    check("map", monitorBits, {7'h40, 7'h01});
    cyc(8);
    check("contactor", mainContactor, 1'b1);
    cyc(4);
    check("contactor", mainContactor, 1'b0);
    check("block", baseBlock, 2'h1);
    cyc(10);
    check("block", baseBlock, 2'h3);
    check("undervolt", undervoltageAlarm, 2'h2);
    alarmClear = 1'b1;
    cyc(1);
    alarmClear = 1'b0;
    cyc(1);
    check("undervolt", undervoltageAlarm, 2'h0);
    stopInputPos = 1'b1;
    cyc(3);
    check("block", baseBlock, 2'h0);
    check("map", monitorBits, 14'h0);
    check("contactor", mainContactor, 1'b1);
    $display("test sequence done");
    cfgContactorEnable = 2'h2;
    stopTorqueLimit = {10'h3ff, 10'h0};
    restart();
    go_stop();
    cyc(20);
    check("contactor", mainContactor, 1'b1);
    check("power", decelTorquePower, {10'h320, 10'h0});
    check("regen", decelTorqueRegen, {10'h320, 10'h0});
    stopInputPos = 1'b1;
    stopTorqueLimit = {10'h320, 10'h1f4};
    overtravel = 2'h3;
    cyc(3);
    check("power", decelTorquePower, {10'h78, 10'h1f4});
    check("regen", decelTorqueRegen, {10'h64, 10'h1f4});
    check("decel", decelActive, 2'h3);
    overtravel = 2'h0;
    cyc(3);
    $display("test torque done");
    stall = 1'b1;
    go_stop();
    cyc(39996);
    check("stopfail", stopFailAlarm, 2'h0);
    cyc(8);
    check("stopfail", stopFailAlarm, 2'h3);
    {stall, stopInputPos, alarmClear} = 3'h7;
    cyc(30);
    alarmClear = 1'b0;
    cyc(1);
    check("stopfail", stopFailAlarm, 2'h0);
    $display("test stop failure done");
    final_report();
  end
endmodule : tb
